// File: include/cic_consts.svh
// Register offsets, field positions, reset values and codes of the core control block.
`ifndef CIC_CONSTS_SVH
`define CIC_CONSTS_SVH
`define CIC_ADDR_W        8
`define CIC_OFF_OPTION    8'h00
`define CIC_OFF_INTCTL    8'h04
`define CIC_OFF_COUNT     8'h08
`define CIC_OFF_STATUS    8'h0C
`define CIC_OFF_MASK      8'h10
`define CIC_OPTION_RST    8'hFF
`define CIC_INTCTL_RST    8'h00
`define CIC_EVT_RST       3'h0
`define CIC_OPT_PUDIS     7
`define CIC_OPT_EXTEDGE   6
`define CIC_OPT_CLKSRC    5
`define CIC_OPT_SRCEDGE   4
`define CIC_OPT_ASSIGN    3
`define CIC_IC_GLOBAL     7
`define CIC_IC_PERIPH     6
`define CIC_IC_TMREN      5
`define CIC_IC_EXTEN      4
`define CIC_IC_PCEN       3
`define CIC_IC_TMRFLAG    2
`define CIC_IC_EXTFLAG    1
`define CIC_IC_PCFLAG     0
`define CIC_RESP_OKAY     2'h0
`define CIC_RESP_SLVERR   2'h2
`endif

// File: include/cic_pkg.sv
// Types shared by the core control block.
package cic_pkg;
   typedef logic [7:0] cic_byte_t;
   typedef logic [1:0] cic_resp_t;
   typedef logic [2:0] cic_evt_t;
endpackage

// File: verilog/cic_core_ctrl.sv
// Option and interrupt control registers with timer, prescaler and AXI4-Lite slave.
`timescale 1ns/1ps
`include "cic_consts.svh"
// Summary of operation
// - Pull-up disable bit forces all pull-ups off.
// - Edge select picks external interrupt edge.
// - Clock source picks instruction clock or pin.
// - Source edge picks counting pin transition.
// - Shared prescaler serves timer or watchdog.
// - Global enable gates every core request.
// - Peripheral enable gates peripheral sources.
// - Per-source enables mask their own request.
// - Timer overflow sets sticky flag.
// - Selected external edge sets sticky flag.
// - Enabled port pin change sets sticky flag.
// - Flags set regardless of enable bits.
// - Only change-enabled pins raise change flag.
// - Timer count survives reset.
module cic_core_ctrl
(
   input  wire logic              clk_sys,
   input  wire logic              resetn,
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output cic_pkg::cic_resp_t     s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output cic_pkg::cic_resp_t     s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              ext_irq_pin,
   input  wire logic              tmr_ext_clk_pin,
   input  wire cic_pkg::cic_byte_t port_pins,
   input  wire cic_pkg::cic_byte_t per_pin_pullup_enables,
   input  wire cic_pkg::cic_byte_t per_pin_change_enables,
   input  wire logic              periph_irq_req,
   input  wire logic              wdt_raw_tick,
   output cic_pkg::cic_byte_t     pullup_en,
   output logic                   wdt_tick,
   output logic                   core_irq_req,
   output logic                   irq
);
   import cic_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Register state and bus state.
   cic_byte_t option_control;
   cic_byte_t interrupt_control;
   cic_byte_t tmr_count;
   cic_byte_t presc;
   cic_evt_t  irq_status;
   cic_evt_t  irq_mask;
   cic_byte_t port_prev;
   logic      ext_prev;
   logic      clk_prev;
   logic      aw_full;
   logic      w_full;
   logic [7:0] aw_addr;
   cic_byte_t w_data;
   logic      w_lane0;
   cic_resp_t bresp;
   logic      bvalid;
   logic [31:0] rdata;
   cic_resp_t rresp;
   logic      rvalid;

   cic_byte_t next_option_control;
   cic_byte_t next_interrupt_control;
   cic_byte_t next_tmr_count;
   cic_byte_t next_presc;
   cic_evt_t  next_irq_status;
   cic_evt_t  next_irq_mask;
   logic      next_aw_full;
   logic      next_w_full;
   logic [7:0] next_aw_addr;
   cic_byte_t next_w_data;
   logic      next_w_lane0;
   cic_resp_t next_bresp;
   logic      next_bvalid;
   logic [31:0] next_rdata;
   cic_resp_t next_rresp;
   logic      next_rvalid;

   ////////////////////////////////////////////////////////////////////////////
   // Event detection on pins and the counting chain.
   logic      ext_rise;
   logic      ext_fall;
   logic      ext_evt;
   logic      clk_edge;
   logic      src_tick;
   logic      to_wdt;
   logic [8:0] tmr_mask9;
   logic [8:0] wdt_mask9;
   logic      presc_step;
   logic      tmr_inc;
   logic      tmr_ovf;
   logic      pc_evt;
   logic      do_write;
   logic      do_read;
   logic      wr_option;
   logic      wr_intctl;
   logic      wr_count;
   logic      wr_mask;
   logic      rd_status;
   cic_evt_t  evt;

   // Edge detection against the previous sample of each pin.
   assign ext_rise = ext_irq_pin & ~ext_prev;
   assign ext_fall = ~ext_irq_pin & ext_prev;
   assign ext_evt  = option_control[`CIC_OPT_EXTEDGE] ? ext_rise : ext_fall;
   assign clk_edge = option_control[`CIC_OPT_SRCEDGE]
                     ? (~tmr_ext_clk_pin & clk_prev)
                     : (tmr_ext_clk_pin & ~clk_prev);
   assign src_tick = option_control[`CIC_OPT_CLKSRC] ? clk_edge : 1'b1;
   assign pc_evt   = |((port_pins ^ port_prev) & per_pin_change_enables);

   // One prescaler: its step source and terminal masks follow the assignment.
   assign to_wdt     = option_control[`CIC_OPT_ASSIGN];
   assign tmr_mask9  = (9'h002 << option_control[2:0]) - 9'h001;
   assign wdt_mask9  = (9'h001 << option_control[2:0]) - 9'h001;
   assign presc_step = to_wdt ? wdt_raw_tick : src_tick;
   assign tmr_inc    = to_wdt ? src_tick
                       : (src_tick && ((presc | ~tmr_mask9[7:0]) == 8'hFF));
   assign wdt_tick   = to_wdt && wdt_raw_tick
                       && ((presc | ~wdt_mask9[7:0]) == 8'hFF);
   assign tmr_ovf    = tmr_inc && (tmr_count == 8'hFF);
   assign evt        = {tmr_ovf, ext_evt, pc_evt};

   // Pull-ups follow their own enables unless globally disabled.
   assign pullup_en = option_control[`CIC_OPT_PUDIS] ? 8'h00 : per_pin_pullup_enables;

   // Core request: global gate over enabled flags and gated peripherals.
   assign core_irq_req = interrupt_control[`CIC_IC_GLOBAL]
      && ((interrupt_control[`CIC_IC_TMREN] && interrupt_control[`CIC_IC_TMRFLAG])
       || (interrupt_control[`CIC_IC_EXTEN] && interrupt_control[`CIC_IC_EXTFLAG])
       || (interrupt_control[`CIC_IC_PCEN] && interrupt_control[`CIC_IC_PCFLAG])
       || (interrupt_control[`CIC_IC_PERIPH] && periph_irq_req));

   // System interrupt line from the sticky status and its mask.
   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // Bus decode.
   assign s_axi_awready = ~aw_full & ~bvalid;
   assign s_axi_wready  = ~w_full & ~bvalid;
   assign s_axi_arready = ~rvalid;
   assign s_axi_bvalid  = bvalid;
   assign s_axi_bresp   = bresp;
   assign s_axi_rvalid  = rvalid;
   assign s_axi_rdata   = rdata;
   assign s_axi_rresp   = rresp;
   assign do_write  = aw_full & w_full & ~bvalid;
   assign do_read   = s_axi_arvalid & ~rvalid;
   assign wr_option = do_write && w_lane0 && (aw_addr == `CIC_OFF_OPTION);
   assign wr_intctl = do_write && w_lane0 && (aw_addr == `CIC_OFF_INTCTL);
   assign wr_count  = do_write && w_lane0 && (aw_addr == `CIC_OFF_COUNT);
   assign wr_mask   = do_write && w_lane0 && (aw_addr == `CIC_OFF_MASK);
   assign rd_status = do_read && (s_axi_araddr == `CIC_OFF_STATUS);

   // Next values of the bus channels and the read mux.
   always_comb
   begin
      next_aw_full = aw_full;
      next_w_full  = w_full;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_w_lane0 = w_lane0;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (s_axi_awvalid && s_axi_awready)
      begin
         next_aw_full = 1'b1;
         next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
         next_w_full  = 1'b1;
         next_w_data  = s_axi_wdata[7:0];
         next_w_lane0 = s_axi_wstrb[0];
      end
      if (do_write)
      begin
         next_aw_full = 1'b0;
         next_w_full  = 1'b0;
         next_bvalid  = 1'b1;
         if (aw_addr == `CIC_OFF_OPTION || aw_addr == `CIC_OFF_INTCTL
             || aw_addr == `CIC_OFF_COUNT || aw_addr == `CIC_OFF_MASK
             || aw_addr == `CIC_OFF_STATUS)
            next_bresp = `CIC_RESP_OKAY;
         else
            next_bresp = `CIC_RESP_SLVERR;
      end
      else if (bvalid && s_axi_bready)
         next_bvalid = 1'b0;
      if (do_read)
      begin
         next_rvalid = 1'b1;
         next_rresp  = `CIC_RESP_OKAY;
         next_rdata  = 32'h0000_0000;
         if (s_axi_araddr[7:2] == `CIC_OFF_OPTION >> 2)
            next_rdata[7:0] = option_control;
         else if (s_axi_araddr[7:2] == `CIC_OFF_INTCTL >> 2)
            next_rdata[7:0] = interrupt_control;
         else if (s_axi_araddr[7:2] == `CIC_OFF_COUNT >> 2)
            next_rdata[7:0] = tmr_count;
         else if (s_axi_araddr[7:2] == `CIC_OFF_STATUS >> 2)
            next_rdata[2:0] = irq_status;
         else if (s_axi_araddr[7:2] == `CIC_OFF_MASK >> 2)
            next_rdata[2:0] = irq_mask;
         else
            next_rresp = `CIC_RESP_SLVERR;
      end
      else if (rvalid && s_axi_rready)
         next_rvalid = 1'b0;
   end

   // Next values of the control registers; a hardware set beats a clear.
   always_comb
   begin
      next_option_control    = wr_option ? w_data : option_control;
      next_irq_mask          = wr_mask ? w_data[2:0] : irq_mask;
      next_interrupt_control = wr_intctl ? w_data : interrupt_control;
      if (tmr_ovf)
         next_interrupt_control[`CIC_IC_TMRFLAG] = 1'b1;
      if (ext_evt)
         next_interrupt_control[`CIC_IC_EXTFLAG] = 1'b1;
      if (pc_evt)
         next_interrupt_control[`CIC_IC_PCFLAG] = 1'b1;
      next_irq_status = (rd_status ? 3'h0 : irq_status) | evt;
   end

   // Next values of the prescaler and timer count; a count write restarts the prescaler.
   always_comb
   begin
      next_presc     = presc_step ? presc + 8'h01 : presc;
      next_tmr_count = tmr_inc ? tmr_count + 8'h01 : tmr_count;
      if (wr_count)
      begin
         next_presc     = 8'h00;
         next_tmr_count = w_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers with synchronous reset; pin history is loaded from the pins.
   always_ff @(posedge clk_sys)
   begin
      if (!resetn)
      begin
         option_control    <= `CIC_OPTION_RST;
         interrupt_control <= `CIC_INTCTL_RST;
         presc             <= 8'h00;
         irq_status        <= `CIC_EVT_RST;
         irq_mask          <= `CIC_EVT_RST;
         port_prev         <= port_pins;
         ext_prev          <= ext_irq_pin;
         clk_prev          <= tmr_ext_clk_pin;
         aw_full           <= 1'b0;
         w_full            <= 1'b0;
         aw_addr           <= 8'h00;
         w_data            <= 8'h00;
         w_lane0           <= 1'b0;
         bvalid            <= 1'b0;
         bresp             <= `CIC_RESP_OKAY;
         rvalid            <= 1'b0;
         rdata             <= 32'h0000_0000;
         rresp             <= `CIC_RESP_OKAY;
      end
      else
      begin
         option_control    <= next_option_control;
         interrupt_control <= next_interrupt_control;
         presc             <= next_presc;
         irq_status        <= next_irq_status;
         irq_mask          <= next_irq_mask;
         port_prev         <= port_pins;
         ext_prev          <= ext_irq_pin;
         clk_prev          <= tmr_ext_clk_pin;
         aw_full           <= next_aw_full;
         w_full            <= next_w_full;
         aw_addr           <= next_aw_addr;
         w_data            <= next_w_data;
         w_lane0           <= next_w_lane0;
         bvalid            <= next_bvalid;
         bresp             <= next_bresp;
         rvalid            <= next_rvalid;
         rdata             <= next_rdata;
         rresp             <= next_rresp;
      end
   end

   // Timer count has no reset and keeps counting state across it.
   always_ff @(posedge clk_sys)
   begin
      tmr_count <= next_tmr_count;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks and scenario covers.
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   a_pullup_all_off: assert property (
      option_control[`CIC_OPT_PUDIS] |-> pullup_en == 8'h00)
      else $error("Pull-ups active while disabled.");

   a_ext_rise_flag: assert property (
      option_control[`CIC_OPT_EXTEDGE] && ext_irq_pin && !ext_prev && !wr_intctl
      |=> interrupt_control[`CIC_IC_EXTFLAG])
      else $error("Rising edge did not set external flag.");

   a_ext_wrong_edge: assert property (
      option_control[`CIC_OPT_EXTEDGE] && !ext_irq_pin && ext_prev
      && !interrupt_control[`CIC_IC_EXTFLAG] && !wr_intctl
      |=> !interrupt_control[`CIC_IC_EXTFLAG])
      else $error("Falling edge set flag in rising mode.");

   a_tmr_direct_count: assert property (
      to_wdt && !option_control[`CIC_OPT_CLKSRC] && !wr_count
      |=> tmr_count == $past(tmr_count) + 8'h01)
      else $error("Timer did not step on instruction clock.");

   a_pin_src_hold: assert property (
      option_control[`CIC_OPT_CLKSRC] && tmr_ext_clk_pin == clk_prev && !wr_count
      |=> $stable(tmr_count))
      else $error("Timer moved without a pin transition.");

   a_wdt_tick_route: assert property (
      (to_wdt && option_control[2:0] == 3'h0 && wdt_raw_tick |-> wdt_tick)
      and (!to_wdt |-> !wdt_tick))
      else $error("Watchdog tick routing wrong.");

   a_global_gate: assert property (
      !interrupt_control[`CIC_IC_GLOBAL] |-> !core_irq_req)
      else $error("Core request without global enable.");

   a_periph_gate: assert property (
      interrupt_control[7:6] == 2'b11 && periph_irq_req |-> core_irq_req)
      else $error("Enabled peripheral request lost.");

   a_flag_sticky: assert property (
      interrupt_control[`CIC_IC_TMRFLAG] && !wr_intctl
      |=> interrupt_control[`CIC_IC_TMRFLAG] [*1] ##0 $stable(interrupt_control[2]))
      else $error("Overflow flag dropped without a write.");

   a_ovf_sets_flag: assert property (
      tmr_ovf |=> interrupt_control[`CIC_IC_TMRFLAG] ##1 1'b1)
      else $error("Overflow did not set its flag.");

   a_change_masked: assert property (
      per_pin_change_enables == 8'h00 && !interrupt_control[`CIC_IC_PCFLAG] && !wr_intctl
      |=> !interrupt_control[`CIC_IC_PCFLAG])
      else $error("Change flag set by unenabled pin.");

   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("Write response dropped early.");

   c_core_request: cover property ($rose(core_irq_req));
   c_ext_flag_set: cover property ($rose(interrupt_control[`CIC_IC_EXTFLAG]));
   c_wdt_scaled:   cover property (wdt_tick ##1 !wdt_tick);
   c_timer_wrap:   cover property (tmr_ovf);
endmodule

// File: test/cic_far_model.sv
// Far-side model that drives the external pins and peripheral lines.
`timescale 1ns/1ps
module cic_far_model
(
   input  wire logic         clk_sys,
   output logic              ext_irq_pin,
   output logic              tmr_ext_clk_pin,
   output cic_pkg::cic_byte_t port_pins,
   output logic              periph_irq_req,
   output logic              wdt_raw_tick
);
   import cic_pkg::*;
   ////////////////////////////////////////////////////////////////////////////
   // Pins start idle and low so no edge is seen after reset.
   initial
   begin
      ext_irq_pin = 1'b0;
      tmr_ext_clk_pin = 1'b0;
      port_pins = 8'h00;
      periph_irq_req = 1'b0;
      wdt_raw_tick = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Each change lands after an edge and is held long enough to be sampled.
   task automatic set_ext(input logic v);
      @(posedge clk_sys);
      ext_irq_pin <= v;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic set_clk(input logic v);
      @(posedge clk_sys);
      tmr_ext_clk_pin <= v;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic clk_falls(input int n);
      repeat (n)
      begin
         set_clk(1'b1);
         set_clk(1'b0);
      end
   endtask
   task automatic set_port(input cic_byte_t v);
      @(posedge clk_sys);
      port_pins <= v;
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic set_periph(input logic v);
      @(posedge clk_sys);
      periph_irq_req <= v;
      repeat (3) @(posedge clk_sys);
   endtask
   // The watchdog base tick is a one-cycle pulse.
   task automatic wdt_pulse();
      @(posedge clk_sys);
      wdt_raw_tick <= 1'b1;
      @(posedge clk_sys);
      wdt_raw_tick <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask
endmodule

// File: test/cic_core_ctrl_tb.sv
// Self-checking bench for the option and interrupt control block.
`timescale 1ns/1ps
`include "cic_consts.svh"
module cic_core_ctrl_tb;
   import cic_pkg::*;
   localparam logic [7:0] r_opt = `CIC_OFF_OPTION;
   localparam logic [7:0] r_ic  = `CIC_OFF_INTCTL;
   localparam logic [7:0] r_cnt = `CIC_OFF_COUNT;
   localparam logic [7:0] r_st  = `CIC_OFF_STATUS;
   localparam logic [7:0] r_msk = `CIC_OFF_MASK;
   logic        clk_sys = 1'b0;
   logic        resetn  = 1'b0;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0000_0000;
   logic        awvalid = 1'b0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   cic_byte_t   pu_en   = 8'hA5;
   cic_byte_t   chg_en  = 8'h00;
   logic [3:0]  wstrb   = 4'hF;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        ext_pin, tclk, periph, raw, wdt_tick, core_irq_req, irq;
   logic [31:0] rdata;
   cic_resp_t   bresp, rresp;
   cic_byte_t   port, pullup_en;
   int          fail_count = 0;
   int          n_compared = 0;
   int          wdt_seen = 0;
   ////////////////////////////////////////////////////////////////////////////
   // Clock and the block with its far side.
   always #5 clk_sys = ~clk_sys;
   cic_core_ctrl uut
   (
      .clk_sys(clk_sys), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_irq_pin(ext_pin), .tmr_ext_clk_pin(tclk), .port_pins(port),
      .per_pin_pullup_enables(pu_en), .per_pin_change_enables(chg_en),
      .periph_irq_req(periph), .wdt_raw_tick(raw), .pullup_en(pullup_en),
      .wdt_tick(wdt_tick), .core_irq_req(core_irq_req), .irq(irq)
   );
   cic_far_model far
   (
      .clk_sys(clk_sys), .ext_irq_pin(ext_pin), .tmr_ext_clk_pin(tclk),
      .port_pins(port), .periph_irq_req(periph), .wdt_raw_tick(raw)
   );
   // Counts prescaled watchdog ticks.
   always @(posedge clk_sys)
      if (wdt_tick === 1'b1)
         wdt_seen <= wdt_seen + 1;
   ////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and bus cycles.
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Address and data go out together; each drops at its own handshake.
   task automatic wr(input logic [7:0] a, input cic_byte_t d,
                     input cic_resp_t er = `CIC_RESP_OKAY);
      logic ta, tw, done;
      cic_resp_t r;
      int n;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++)
      begin
         @(negedge clk_sys);
         ta = awvalid & awready;
         tw = wvalid & wready;
         done = bvalid;
         r = bresp;
         @(posedge clk_sys);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
         if (done) bready <= 1'b0;
      end
      check({done, r}, {1'b1, er});
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input cic_resp_t er);
      logic ta, done;
      cic_resp_t r;
      int n;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 40 && !done; n++)
      begin
         @(negedge clk_sys);
         ta = arvalid & arready;
         done = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (ta) arvalid <= 1'b0;
         if (done) rready <= 1'b0;
      end
      check({done, r}, {1'b1, er});
   endtask
   task automatic rc(input logic [7:0] a, input cic_byte_t e,
                     input cic_resp_t er = `CIC_RESP_OKAY);
      logic [31:0] v;
      rd(a, v, er);
      check(v, {24'h000000, e});
   endtask
   // Core request and interrupt line, looked at mid-cycle.
   task automatic lines(input logic [1:0] e);
      @(negedge clk_sys);
      check({core_irq_req, irq}, e);
   endtask
   task automatic do_reset();
      @(posedge clk_sys);
      resetn <= 1'b0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Reset values, unmapped place and pull-up gating.
   task automatic t_reset();
      rc(r_opt, 8'hFF);
      rc(r_ic, 8'h00);
      rc(r_st, 8'h00);
      rc(r_msk, 8'h00);
      rc(8'h14, 8'h00, `CIC_RESP_SLVERR);
      wr(8'h14, 8'h55, `CIC_RESP_SLVERR);
      lines(2'b00);
      check(pullup_en, 8'h00);
      wr(r_opt, 8'h7F);
      lines(2'b00);
      check(pullup_en, 8'hA5);
      pu_en <= 8'h5A;
      lines(2'b00);
      check(pullup_en, 8'h5A);
      wr(r_opt, 8'hFF);
      lines(2'b00);
      check(pullup_en, 8'h00);
      // A write whose low lane is not strobed is answered but stores nothing.
      wstrb <= 4'h0;
      wr(r_opt, 8'h00);
      wstrb <= 4'hF;
      rc(r_opt, 8'hFF);
   endtask
   // Timer source, edge, prescaler sharing and overflow flag.
   task automatic t_timer();
      logic [31:0] c1, c2;
      wr(r_cnt, 8'h00);
      wr(r_opt, 8'h18);
      rd(r_cnt, c1, `CIC_RESP_OKAY);
      rd(r_cnt, c2, `CIC_RESP_OKAY);
      check(c1 != c2, 1'b1);
      wr(r_opt, 8'h38);
      wr(r_cnt, 8'hFD);
      far.set_clk(1'b1);
      rc(r_cnt, 8'hFD);
      far.set_clk(1'b0);
      far.clk_falls(1);
      rc(r_cnt, 8'hFF);
      rc(r_ic, 8'h00);
      far.clk_falls(1);
      rc(r_cnt, 8'h00);
      rc(r_ic, 8'h04);
      wr(r_ic, 8'h00);
      rc(r_ic, 8'h00);
      wr(r_opt, 8'h30);
      wr(r_cnt, 8'h10);
      far.clk_falls(4);
      rc(r_cnt, 8'h12);
      wr(r_opt, 8'h31);
      wr(r_cnt, 8'h10);
      far.clk_falls(4);
      rc(r_cnt, 8'h11);
      wr(r_opt, 8'h28);
      wr(r_cnt, 8'h10);
      far.set_clk(1'b1);
      rc(r_cnt, 8'h11);
      far.set_clk(1'b0);
      rc(r_cnt, 8'h11);
      wr(r_opt, 8'h39);
      wdt_seen = 0;
      repeat (4) far.wdt_pulse();
      check(wdt_seen, 32'd2);
      wr(r_opt, 8'h38);
      wdt_seen = 0;
      repeat (2) far.wdt_pulse();
      check(wdt_seen, 32'd2);
   endtask
   // External pin edge selection and sticky flag.
   task automatic t_ext();
      wr(r_opt, 8'hE8);
      far.set_ext(1'b1);
      rc(r_ic, 8'h02);
      wr(r_ic, 8'h00);
      rc(r_ic, 8'h00);
      far.set_ext(1'b0);
      rc(r_ic, 8'h00);
      wr(r_opt, 8'hA8);
      far.set_ext(1'b1);
      rc(r_ic, 8'h00);
      far.set_ext(1'b0);
      rc(r_ic, 8'h02);
   endtask
   // Global, peripheral and per-source gating of the core request.
   task automatic t_gate();
      wr(r_ic, 8'h12);
      lines(2'b00);
      wr(r_ic, 8'h92);
      lines(2'b10);
      wr(r_ic, 8'h82);
      lines(2'b00);
      wr(r_ic, 8'h00);
      far.set_periph(1'b1);
      wr(r_ic, 8'h80);
      lines(2'b00);
      wr(r_ic, 8'hC0);
      lines(2'b10);
      far.set_periph(1'b0);
      lines(2'b00);
      wr(r_ic, 8'h00);
   endtask
   // Port change flag needs the pin's change enable.
   task automatic t_port();
      chg_en <= 8'h01;
      far.set_port(8'h02);
      rc(r_ic, 8'h00);
      far.set_port(8'h03);
      rc(r_ic, 8'h01);
      wr(r_ic, 8'h81);
      lines(2'b00);
      wr(r_ic, 8'h89);
      lines(2'b10);
      wr(r_ic, 8'h00);
      chg_en <= 8'hFE;
      far.set_port(8'h02);
      rc(r_ic, 8'h00);
      far.set_port(8'hFD);
      rc(r_ic, 8'h01);
      wr(r_ic, 8'h00);
   endtask
   // Status clears on read; mask gates the interrupt line.
   task automatic t_status();
      rc(r_st, 8'h07);
      rc(r_st, 8'h00);
      far.set_ext(1'b1);
      far.set_ext(1'b0);
      lines(2'b00);
      rc(r_st, 8'h02);
      wr(r_msk, 8'h02);
      rc(r_msk, 8'h02);
      far.set_ext(1'b1);
      far.set_ext(1'b0);
      lines(2'b01);
      rc(r_st, 8'h02);
      lines(2'b00);
      wr(r_st, 8'h07);
      rc(r_st, 8'h00);
   endtask
   // Timer count survives a reset in mid-run.
   task automatic t_keep();
      rc(r_cnt, 8'h11);
      do_reset();
      rc(r_cnt, 8'h11);
      rc(r_opt, 8'hFF);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence and the watchdog against a hang.
   initial
   begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_reset();
      t_timer();
      t_ext();
      t_gate();
      t_port();
      t_status();
      t_keep();
      finish_test();
   end
   initial
   begin
      repeat (10000) @(posedge clk_sys);
      fail_count++;
      finish_test();
   end
endmodule
